// ===== src/t16_timer.sv
// sixteen bit timer with control registers on a wishbone slave
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
// How it works
// - bits 7..6 of control a steer pin a
// - bits 5..4 of control a steer pin b
// - non-pwm: off, toggle, clear, set
// - pwm: 10 clear up, set down; 11 inverse
// - reserved control bits read as zero
// - pwm select: off, 8, 9, 10 bit
// - filter off: capture on first edge
// - filter on: four equal samples needed
// - edge bit picks falling or rising capture
// - clear on match a, next cycle
// - match detected one cycle after arrival
// - clear on match ignored in pwm
// - clock select: stop, dividers, external edges
// - dividers from cpu clock; stop disables
// - external pin counts even as output
// - external pin sampled on rising clock
// - one shared temp byte for wide access
// - high byte to temp, low loads all
// - low byte write alone loads counter
// - counting resumes after write next cycle
module t16_timer
    import t16_pkg::*;
(
    input wire logic clk_i, // cpu clock
    input wire logic rst_i, // synchronous reset
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic ext_count_pin_i, // external count pin
    input wire logic capture_in_pin_i, // capture pin
    output logic cmp_a_out_pin_o, // compare a pin level
    output logic cmp_a_out_oe_o, // compare a pin owned
    output logic cmp_b_out_pin_o, // compare b pin level
    output logic cmp_b_out_oe_o // compare b pin owned
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] ctrl_a; // control a
        logic [7:0] ctrl_b; // control b
        logic [15:0] cnt; // counter
        logic [7:0] temp; // shared temp byte
        logic [15:0] cmp_a; // compare a value
        logic [15:0] cmp_b; // compare b value
        logic [15:0] cap; // capture value
        logic [9:0] pre; // prescaler
        logic ext_prev; // last external sample
        logic [3:0] hist; // capture samples, bit 0 newest
        logic cap_lvl; // settled capture level
        logic arrived; // counter stepped last cycle
        logic down; // pwm counting down
        logic out_a; // pin a level
        logic out_b; // pin b level
        logic oe_a; // pin a claimed by its mode
        logic oe_b; // pin b claimed by its mode
        logic ack; // bus ack
        logic [31:0] rdat; // bus read data
    } state_t;

    state_t s_q;
    state_t s_d;

    // ==========================================================
    // helpers
    // tick of the selected counter clock
    function automatic logic sel_tick(input logic [2:0] cs, input logic [9:0] pre,
                                      input logic prev, input logic pin);
        case (cs)
            CS_DIV1: sel_tick = 1'b1;
            CS_DIV8: sel_tick = (pre[2:0] == 3'h7);
            CS_DIV64: sel_tick = (pre[5:0] == 6'h3F);
            CS_DIV256: sel_tick = (pre[7:0] == 8'hFF);
            CS_DIV1024: sel_tick = (pre == 10'h3FF);
            CS_EXT_FALL: sel_tick = prev & ~pin;
            CS_EXT_RISE: sel_tick = ~prev & pin;
            default: sel_tick = 1'b0;
        endcase
    endfunction

    // pwm turning point
    function automatic logic [15:0] pwm_top(input logic [1:0] sel);
        case (sel)
            2'h1: pwm_top = TOP_8;
            2'h2: pwm_top = TOP_9;
            default: pwm_top = TOP_10;
        endcase
    endfunction

    // pin level after a match
    function automatic logic pin_next(input logic [1:0] mode, input logic pwm,
                                      input logic down, input logic cur);
        if (!pwm) begin
            case (mode)
                MODE_TOGGLE: pin_next = ~cur;
                MODE_CLEAR: pin_next = 1'b0;
                MODE_SET: pin_next = 1'b1;
                default: pin_next = cur;
            endcase
        end else begin
            case (mode)
                MODE_CLEAR: pin_next = down;
                MODE_SET: pin_next = ~down;
                default: pin_next = cur;
            endcase
        end
    endfunction

    // ==========================================================
    // decoded controls
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic [1:0] pwm_sel;
    logic [2:0] clk_sel;
    logic pwm_on;
    logic filt_on;
    logic edge_sel;
    logic ctc_on;
    assign mode_a = s_q.ctrl_a[POS_MODE_A +: 2];
    assign mode_b = s_q.ctrl_a[POS_MODE_B +: 2];
    assign pwm_sel = s_q.ctrl_a[POS_PWM +: 2];
    assign clk_sel = s_q.ctrl_b[POS_CS +: 3];
    assign pwm_on = (pwm_sel != PWM_OFF);
    assign filt_on = s_q.ctrl_b[POS_FILT];
    assign edge_sel = s_q.ctrl_b[POS_EDGE];
    assign ctc_on = s_q.ctrl_b[POS_CTC];

    // bus request decode
    logic req;
    logic wr;
    logic rd;
    logic [5:0] idx;
    logic [7:0] wbyte;
    logic wr_cnt_lo;
    logic [15:0] ld_val;
    assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign rd = req & ~wb_we_i;
    assign idx = wb_adr_i[7:2];
    assign wbyte = wb_dat_i[7:0];
    assign wr_cnt_lo = wr & (idx == IDX_CNT_LO);
    assign ld_val = {s_q.temp, wbyte};

    // counter clock and events
    logic tick;
    logic match_a;
    logic match_b;
    logic ctc_clr;
    logic [15:0] top;
    assign tick = sel_tick(clk_sel, s_q.pre, s_q.ext_prev, ext_count_pin_i);
    assign top = pwm_top(pwm_sel);
    // a match is seen the cycle after the counter arrived
    assign match_a = s_q.arrived & (pwm_on ? (s_q.cnt[9:0] == s_q.cmp_a[9:0])
                                           : (s_q.cnt == s_q.cmp_a));
    assign match_b = s_q.arrived & (pwm_on ? (s_q.cnt[9:0] == s_q.cmp_b[9:0])
                                           : (s_q.cnt == s_q.cmp_b));
    assign ctc_clr = match_a & ctc_on & ~pwm_on;

    // capture level tracking
    logic new_lvl;
    logic cap_trig;
    always_comb begin
        if (filt_on) begin
            // settle only on four equal samples
            if (s_q.hist == {FILT_LEN{1'b1}}) begin
                new_lvl = 1'b1;
            end else if (s_q.hist == {FILT_LEN{1'b0}}) begin
                new_lvl = 1'b0;
            end else begin
                new_lvl = s_q.cap_lvl;
            end
        end else begin
            new_lvl = s_q.hist[0];
        end
    end
    assign cap_trig = (new_lvl != s_q.cap_lvl) & (new_lvl == edge_sel);

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        s_d.pre = 10'(s_q.pre + 10'h001);
        s_d.ext_prev = ext_count_pin_i;
        s_d.hist = {s_q.hist[2:0], capture_in_pin_i};
        s_d.cap_lvl = new_lvl;
        s_d.arrived = 1'b0;
        // counting
        if (ctc_clr) begin
            s_d.cnt = RST_WORD;
        end else if (tick) begin
            s_d.arrived = 1'b1;
            if (!pwm_on) begin
                s_d.cnt = 16'(s_q.cnt + 16'h0001);
            end else if (!s_q.down) begin
                if (s_q.cnt >= top) begin
                    s_d.down = 1'b1;
                    s_d.cnt = 16'(s_q.cnt - 16'h0001);
                end else begin
                    s_d.cnt = 16'(s_q.cnt + 16'h0001);
                end
            end else begin
                if (s_q.cnt == RST_WORD) begin
                    s_d.down = 1'b0;
                    s_d.cnt = 16'h0001;
                end else begin
                    s_d.cnt = 16'(s_q.cnt - 16'h0001);
                end
            end
        end
        if (!pwm_on) begin
            s_d.down = 1'b0;
        end
        // compare pin actions
        if (match_a) begin
            s_d.out_a = pin_next(mode_a, pwm_on, s_q.down, s_q.out_a);
        end
        if (match_b) begin
            s_d.out_b = pin_next(mode_b, pwm_on, s_q.down, s_q.out_b);
        end
        // pin ownership follows the mode, one cycle behind a control write
        s_d.oe_a = pwm_on ? mode_a[1] : (mode_a != MODE_OFF);
        s_d.oe_b = pwm_on ? mode_b[1] : (mode_b != MODE_OFF);
        // capture
        if (cap_trig) begin
            s_d.cap = s_q.cnt;
        end
        // register writes
        if (wr) begin
            case (idx)
                IDX_CTRL_A: s_d.ctrl_a = wbyte & MASK_CTRL_A;
                IDX_CTRL_B: s_d.ctrl_b = wbyte & MASK_CTRL_B;
                IDX_CNT_HI, IDX_CMPA_HI, IDX_CMPB_HI: s_d.temp = wbyte;
                IDX_CNT_LO: begin
                    s_d.cnt = ld_val;
                    s_d.arrived = 1'b0;
                end
                IDX_CMPA_LO: s_d.cmp_a = ld_val;
                IDX_CMPB_LO: s_d.cmp_b = ld_val;
                default: s_d.temp = s_q.temp;
            endcase
        end
        // register reads
        s_d.rdat = 32'h0000_0000;
        if (rd) begin
            case (idx)
                IDX_CTRL_A: s_d.rdat[7:0] = s_q.ctrl_a;
                IDX_CTRL_B: s_d.rdat[7:0] = s_q.ctrl_b;
                IDX_CNT_LO: begin
                    s_d.rdat[7:0] = s_q.cnt[7:0];
                    s_d.temp = s_q.cnt[15:8];
                end
                IDX_CAP_LO: begin
                    s_d.rdat[7:0] = s_q.cap[7:0];
                    s_d.temp = s_q.cap[15:8];
                end
                IDX_CNT_HI, IDX_CAP_HI: s_d.rdat[7:0] = s_q.temp;
                IDX_CMPA_HI: s_d.rdat[7:0] = s_q.cmp_a[15:8];
                IDX_CMPA_LO: s_d.rdat[7:0] = s_q.cmp_a[7:0];
                IDX_CMPB_HI: s_d.rdat[7:0] = s_q.cmp_b[15:8];
                IDX_CMPB_LO: s_d.rdat[7:0] = s_q.cmp_b[7:0];
                default: s_d.rdat = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, all from flip-flops
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign cmp_a_out_pin_o = s_q.out_a;
    assign cmp_b_out_pin_o = s_q.out_b;
    // pin handed to the port once the mode claims it
    assign cmp_a_out_oe_o = s_q.oe_a;
    assign cmp_b_out_oe_o = s_q.oe_b;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ext_rise;
        (clk_sel == CS_EXT_RISE) && !s_q.ext_prev && ext_count_pin_i;
    endsequence

    sequence s_free_step;
        !pwm_on && !wr_cnt_lo && !ctc_clr;
    endsequence

    AST_RSVD: assert property (s_q.ctrl_a[3:2] == 2'h0 && s_q.ctrl_b[5:4] == 2'h0)
        else $error("reserved control bits not zero");
    AST_CNT_LOAD: assert property (wr_cnt_lo |=> s_q.cnt == $past(ld_val))
        else $error("counter not loaded from temp and low byte");
    AST_STOP: assert property ((clk_sel == CS_STOP) && !wr_cnt_lo && !ctc_clr
                               |=> $stable(s_q.cnt))
        else $error("stopped counter moved");
    AST_CTC: assert property (ctc_clr && !wr_cnt_lo |=> s_q.cnt == 16'h0000)
        else $error("counter not cleared after compare a");
    AST_PWM_NO_CTC: assert property (pwm_on && ctc_on && match_a && !wr_cnt_lo
                                     && s_q.cnt > 16'h0001 |=> s_q.cnt != 16'h0000)
        else $error("clear on compare acted in pwm");
    AST_EXT: assert property (s_ext_rise and s_free_step
                              |=> s_q.cnt == 16'($past(s_q.cnt) + 16'h0001))
        else $error("external rising edge did not count");
    AST_CAP: assert property (cap_trig |=> s_q.cap == $past(s_q.cnt))
        else $error("capture did not take counter");
    AST_FILT: assert property (cap_trig && filt_on |-> s_q.hist == {4{edge_sel}})
        else $error("filtered capture without four samples");
    AST_TOGGLE: assert property (match_a && !pwm_on && mode_a == MODE_TOGGLE
                                 |=> s_q.out_a != $past(s_q.out_a))
        else $error("toggle mode did not toggle");
    AST_PWM_PIN: assert property (match_a && pwm_on && mode_a == MODE_CLEAR && !s_q.down
                                  |=> !s_q.out_a)
        else $error("pwm up match did not clear");
    AST_MATCH_LATE: assert property (tick && !ctc_clr && !wr_cnt_lo && !pwm_on
                                     |=> match_a == (s_q.cnt == s_q.cmp_a))
        else $error("match not seen the cycle after arrival");
    AST_ACK: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not single cycle");

    // counter steps onto compare a with clear on match armed
    sequence s_step_onto_a;
        tick && !pwm_on && ctc_on && !wr && 16'(s_q.cnt + 16'h0001) == s_q.cmp_a;
    endsequence

    AST_CTC_SEQ: assert property (s_step_onto_a ##1 !wr_cnt_lo
                                  |=> s_q.cnt == RST_WORD)
        else $error("step onto compare a did not clear two cycles later");
    AST_SET_PIN: assert property (match_a && !pwm_on && mode_a == MODE_SET
                                  |=> s_q.out_a)
        else $error("set mode did not raise pin a");
    AST_CLEAR_B: assert property (match_b && !pwm_on && mode_b == MODE_CLEAR
                                  |=> !s_q.out_b)
        else $error("clear mode did not lower pin b");
    AST_OFF_HOLD: assert property (!pwm_on && mode_a == MODE_OFF
                                   |=> s_q.out_a == $past(s_q.out_a))
        else $error("disconnected pin a moved");
    AST_PWM_DOWN: assert property (match_a && pwm_on && mode_a == MODE_CLEAR && s_q.down
                                   |=> s_q.out_a)
        else $error("pwm down match did not set");
    AST_PWM_LOOSE: assert property (pwm_on && !mode_a[1]
                                    |=> s_q.out_a == $past(s_q.out_a))
        else $error("unconnected pwm pin a moved");
    AST_OE_OFF: assert property (!pwm_on && mode_a == MODE_OFF
                                 |=> !cmp_a_out_oe_o)
        else $error("pin a claimed while disconnected");
    AST_DIV8_HOLD: assert property (clk_sel == CS_DIV8 && s_q.pre[2:0] != 3'h7
                                    && !wr_cnt_lo && !ctc_clr |=> $stable(s_q.cnt))
        else $error("divide by eight counted off its tick");
    AST_TEMP_HI: assert property (wr && idx == IDX_CNT_HI
                                  |=> s_q.temp == $past(wbyte))
        else $error("high count byte not held in temp");
    AST_NOFILT: assert property (cap_trig && !filt_on
                                 |-> s_q.hist[0] == edge_sel)
        else $error("unfiltered capture off the newest sample");

endmodule

// ===== src/t16_pkg.sv
// constants for the sixteen bit timer control block
package t16_pkg;
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_CTRL_A = 6'h2F;
    localparam logic [5:0] IDX_CTRL_B = 6'h2E;
    localparam logic [5:0] IDX_CNT_HI = 6'h2D;
    localparam logic [5:0] IDX_CNT_LO = 6'h2C;
    localparam logic [5:0] IDX_CMPA_HI = 6'h2B;
    localparam logic [5:0] IDX_CMPA_LO = 6'h2A;
    localparam logic [5:0] IDX_CMPB_HI = 6'h29;
    localparam logic [5:0] IDX_CMPB_LO = 6'h28;
    localparam logic [5:0] IDX_CAP_HI = 6'h27;
    localparam logic [5:0] IDX_CAP_LO = 6'h26;
    // writable bit masks, the rest are reserved
    localparam logic [7:0] MASK_CTRL_A = 8'hF3;
    localparam logic [7:0] MASK_CTRL_B = 8'hCF;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // field positions in control a
    localparam int POS_MODE_A = 6;
    localparam int POS_MODE_B = 4;
    localparam int POS_PWM = 0;
    // field positions in control b
    localparam int POS_FILT = 7;
    localparam int POS_EDGE = 6;
    localparam int POS_CTC = 3;
    localparam int POS_CS = 0;
    // compare output modes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_TOGGLE = 2'h1;
    localparam logic [1:0] MODE_CLEAR = 2'h2;
    localparam logic [1:0] MODE_SET = 2'h3;
    // clock selections
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // pwm resolutions and turning points
    localparam logic [1:0] PWM_OFF = 2'h0;
    localparam logic [15:0] TOP_8 = 16'h00FF;
    localparam logic [15:0] TOP_9 = 16'h01FF;
    localparam logic [15:0] TOP_10 = 16'h03FF;
    // samples the capture filter must see
    localparam int FILT_LEN = 4;
endpackage

// ===== bench/testbench.sv
// self-checking bench for the sixteen bit timer control block
`timescale 1ns/1ps
module testbench;
    import t16_pkg::*;
    // ==========================================
    // signals
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wb_ack_o, ext_count_pin_i, capture_in_pin_i;
    logic cmp_a_out_pin_o, cmp_a_out_oe_o, cmp_b_out_pin_o, cmp_b_out_oe_o;
    int failures = 0; // mismatches
    int samples_checked = 0; // comparisons
    logic [15:0] tops [3] = '{TOP_8, TOP_9, TOP_10}; // pwm turning points

    t16_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_count_pin_i(ext_count_pin_i),
        .capture_in_pin_i(capture_in_pin_i), .cmp_a_out_pin_o(cmp_a_out_pin_o),
        .cmp_a_out_oe_o(cmp_a_out_oe_o), .cmp_b_out_pin_o(cmp_b_out_pin_o),
        .cmp_b_out_oe_o(cmp_b_out_oe_o));

    // ==========================================
    // clock, shared tasks
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // compare seen with expected, count both
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 50) begin
            failures++;
            $display("[FAIL] %0t: no acknowledge", $time);
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        logic [7:0] d;
        bus(1'b1, idx, v, d);
    endtask

    task automatic rd(input logic [5:0] idx, output logic [7:0] v);
        bus(1'b0, idx, 8'h00, v);
    endtask

    // high byte first, then low byte
    task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
        wr(lo + 6'h01, v[15:8]);
        wr(lo, v[7:0]);
    endtask

    // low byte first, high byte from the shared byte
    task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 6'h01, v[15:8]);
    endtask

    // ==========================================
    // scenarios
    task automatic t_regs;
        logic [7:0] b;
        logic [15:0] w;
        rd(IDX_CTRL_A, b); check({8'h00, b}, 16'h0000);
        rd(IDX_CTRL_B, b); check({8'h00, b}, 16'h0000);
        rd16(IDX_CNT_LO, w); check(w, RST_WORD);
        wr(IDX_CTRL_A, 8'hFF); rd(IDX_CTRL_A, b); check({8'h00, b}, 16'h00F3);
        wr(IDX_CTRL_B, 8'hF8); rd(IDX_CTRL_B, b); check({8'h00, b}, 16'h00C8);
        wr(IDX_CTRL_A, 8'h00); wr(IDX_CTRL_B, 8'h00);
        // a write without lane zero is acknowledged and dropped
        wb_sel_i <= 4'hE;
        wr(IDX_CTRL_A, 8'hC0);
        wb_sel_i <= 4'hF;
        rd(IDX_CTRL_A, b); check({8'h00, b}, 16'h0000);
        wr(6'h00, 8'h5A); rd(6'h00, b); check({8'h00, b}, 16'h0000);
        wr16(IDX_CNT_LO, 16'hA55A); rd16(IDX_CNT_LO, w); check(w, 16'hA55A);
        wr16(IDX_CNT_LO, 16'h0012); rd16(IDX_CNT_LO, w);
        wr(IDX_CNT_LO, 8'h3C); rd16(IDX_CNT_LO, w); check(w, 16'h003C);
    endtask

    // each divider runs for eight of its own periods
    task automatic t_prescale;
        logic [15:0] v, v2;
        int d;
        d = 1;
        for (int c = 1; c <= 5; c++) begin
            wr16(IDX_CNT_LO, 16'h0000);
            wr(IDX_CTRL_B, {5'h00, c[2:0]});
            repeat (8 * d) @(posedge clk_i);
            wr(IDX_CTRL_B, {5'h00, CS_STOP});
            rd16(IDX_CNT_LO, v);
            check({15'h0000, (v >= 16'd8 && v <= 16'd12)}, 16'h0001);
            rd16(IDX_CNT_LO, v2); check(v2, v);
            d = (c < 3) ? d * 8 : d * 4;
        end
    endtask

    // software-made edges on the external count pin
    task automatic t_external;
        logic [15:0] v;
        for (int e = 0; e < 2; e++) begin
            wr16(IDX_CNT_LO, 16'h0000);
            wr(IDX_CTRL_B, {5'h00, (e == 0) ? CS_EXT_RISE : CS_EXT_FALL});
            repeat (5) begin
                @(posedge clk_i) ext_count_pin_i <= 1'b1;
                repeat (2) @(posedge clk_i);
                ext_count_pin_i <= 1'b0;
                @(posedge clk_i);
            end
            repeat (4) @(posedge clk_i);
            wr(IDX_CTRL_B, 8'h00);
            rd16(IDX_CNT_LO, v); check(v, 16'd5);
        end
    endtask

    // compare actions with clear on match a
    task automatic t_compare;
        logic [15:0] v;
        logic [7:0] modes [4] = '{8'hF0, 8'hA0, 8'h00, 8'h50};
        wr16(IDX_CMPA_LO, 16'h0005);
        wr16(IDX_CMPB_LO, 16'h0003);
        for (int m = 0; m < 4; m++) begin
            wr16(IDX_CNT_LO, 16'h0000);
            wr(IDX_CTRL_A, modes[m]);
            wr(IDX_CTRL_B, 8'h09);
            repeat (30) @(posedge clk_i);
            wr(IDX_CTRL_B, 8'h00);
            rd16(IDX_CNT_LO, v); check({15'h0000, v <= 16'd5}, 16'h0001);
            check({15'h0000, cmp_a_out_oe_o}, {15'h0000, m != 2});
            check({15'h0000, cmp_b_out_oe_o}, {15'h0000, m != 2});
            if (m < 2) begin
                check({15'h0000, cmp_a_out_pin_o}, {15'h0000, m == 0});
                check({15'h0000, cmp_b_out_pin_o}, {15'h0000, m == 0});
            end
        end
    endtask

    // each pwm width climbs past the match to near its top
    task automatic t_pwm;
        logic [15:0] v;
        logic ok;
        for (int p = 1; p <= 3; p++) begin
            wr16(IDX_CNT_LO, 16'h0000);
            wr(IDX_CTRL_A, {6'h20, p[1:0]});
            wr(IDX_CTRL_B, 8'h09);
            repeat (tops[p-1] - 40) @(posedge clk_i);
            wr(IDX_CTRL_B, 8'h00);
            rd16(IDX_CNT_LO, v);
            check({15'h0000, (v <= tops[p-1] && v >= tops[p-1] - 50)}, 16'h0001);
            check({15'h0000, cmp_a_out_oe_o}, 16'h0001);
            wr(IDX_CTRL_A, {6'h10, p[1:0]});
            repeat (2) @(posedge clk_i);
            check({15'h0000, cmp_a_out_oe_o}, 16'h0000);
        end
        wr(IDX_CTRL_A, 8'h00);
        // 8-bit run over the turn: clear on the way up, set on the way down
        wr16(IDX_CMPA_LO, 16'h0080);
        wr16(IDX_CNT_LO, 16'h0000);
        wr(IDX_CTRL_A, 8'h81);
        for (int s = 0; s < 2; s++) begin
            wr(IDX_CTRL_B, {5'h00, CS_DIV1});
            repeat (200) @(posedge clk_i);
            wr(IDX_CTRL_B, 8'h00);
            rd16(IDX_CNT_LO, v);
            ok = (s == 0) ? (v >= 16'd190 && v <= 16'd215) : (v >= 16'd90 && v <= 16'd120);
            check({15'h0000, ok}, 16'h0001);
            check({15'h0000, cmp_a_out_pin_o}, {15'h0000, s == 1});
        end
        wr(IDX_CTRL_A, 8'h00);
    endtask

    // drive the capture pin for some cycles
    task automatic pin(input logic lvl, input int n);
        @(posedge clk_i) capture_in_pin_i <= lvl;
        repeat (n) @(posedge clk_i);
    endtask

    task automatic t_capture;
        logic [15:0] v;
        wr16(IDX_CNT_LO, 16'h1234);
        wr(IDX_CTRL_B, 8'h40);
        pin(1'b1, 4); rd16(IDX_CAP_LO, v); check(v, 16'h1234);
        wr16(IDX_CNT_LO, 16'h0056);
        wr(IDX_CTRL_B, 8'h00);
        pin(1'b0, 4); rd16(IDX_CAP_LO, v); check(v, 16'h0056);
        wr16(IDX_CNT_LO, 16'h0077);
        wr(IDX_CTRL_B, 8'hC0);
        pin(1'b1, 2); pin(1'b0, 6); rd16(IDX_CAP_LO, v); check(v, 16'h0056);
        pin(1'b1, 8); rd16(IDX_CAP_LO, v); check(v, 16'h0077);
    endtask

    // ==========================================
    // verdict and sequence
    task automatic results;
        $display("checked %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog: the tests need some 15000 cycles, this allows over three times that
    initial begin
        #500_000;
        failures++;
        results();
    end

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h00000000;
        ext_count_pin_i = 1'b0;
        capture_in_pin_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_prescale();
        t_external();
        t_compare();
        t_pwm();
        t_capture();
        results();
    end
endmodule
